// ---- inc/driver_ctrl_map.vh ----
// Register map, field positions and reset values of the modulator driver control bank.
`ifndef DRIVER_CTRL_MAP_VH
`define DRIVER_CTRL_MAP_VH
`define SLAVE_ADDR         7'h08
`define REG_MAIN_CONTROL   8'h00
`define REG_AMPLITUDE      8'h01
`define REG_PEAKING_LEVEL  8'h02
`define REG_EQUALIZER      8'h03
`define REG_CONV_SETTINGS  8'h0d
`define REG_CONV_RES_HIGH  8'h0e
`define REG_CONV_RES_LOW   8'h0f
`define BIT_CHIP_ON        7
`define BIT_HIGH_TERM      6
`define BIT_PEAKING_ON     5
`define BIT_PEAKING_RANGE  4
`define BIT_CROSSING_ADJ   3
`define BIT_OUTPUT_SWAP    2
`define BIT_INPUT_EQ_ON    1
`define BIT_SWING_SOURCE   0
`define BIT_CONVERTER_OFF  7
`define BIT_OSCILLATOR_OFF 6
`define BIT_CONV_INPUT_SEL 0
`define CONV_SETTINGS_MASK 8'hc1
`define PEAKING_LEVEL_MASK 8'h0f
`define RESET_MAIN_CONTROL 8'h00
`define RESET_AMPLITUDE    8'h00
`define RESET_PEAKING      8'h00
`define RESET_EQUALIZER    8'hff
`define RESET_CONV_SET     8'h00
`endif

// ---- verilog/driver_ctrl_regs.v ----
// Two-wire serial slave and control register bank of the modulator driver.
`timescale 1ns/100ps
`include "driver_ctrl_map.vh"
module driver_ctrl_regs (
	// Clock and reset
	input  wire       clk,
	input  wire       reset,
	// Serial bus pins
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe,
	// Converter result
	input  wire [9:0] conv_result,
	// Control outputs
	output reg        chip_on,
	output reg        high_termination_sel,
	output reg        peaking_on,
	output reg        peaking_range,
	output reg        crossing_adjust_on,
	output reg        offset_cancel_on,
	output reg        output_swap,
	output reg        input_eq_on,
	output reg        swing_source_sel,
	output reg  [7:0] swing_code,
	output reg  [3:0] peaking_level,
	output reg  [7:0] boost_code,
	output reg        converter_off,
	output reg        oscillator_off,
	output reg        converter_input_sel
);

	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_ADDR = 6'h02;
	localparam [5:0] S_REG  = 6'h04;
	localparam [5:0] S_DATA = 6'h08;
	localparam [5:0] S_READ = 6'h10;
	localparam [5:0] S_ACK  = 6'h20;

	reg  [5:0] state;
	reg  [5:0] ret_state;
	reg        scl_d;
	reg        sda_d;
	reg  [3:0] bit_cnt;
	reg  [7:0] shifter;
	reg  [7:0] reg_ptr;
	reg        drive_low;
	reg        reading;
	reg  [7:0] main_control;
	reg  [7:0] amplitude_setting;
	reg  [7:0] preemphasis_level;
	reg  [7:0] equalizer_setting;
	reg  [7:0] converter_settings;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_cond;
	wire       stop_cond;
	wire       store_now;
	wire [7:0] read_byte;
	reg        next_chip_on;
	reg        next_high_termination_sel;
	reg        next_peaking_on;
	reg        next_peaking_range;
	reg        next_crossing_adjust_on;
	reg        next_offset_cancel_on;
	reg        next_output_swap;
	reg        next_input_eq_on;
	reg        next_swing_source_sel;
	reg  [7:0] next_swing_code;
	reg  [3:0] next_peaking_level;
	reg  [7:0] next_boost_code;
	reg        next_converter_off;
	reg        next_oscillator_off;
	reg        next_converter_input_sel;

	assign scl_rise   = scl_in & ~scl_d;
	assign scl_fall   = ~scl_in & scl_d;
	assign start_cond = scl_in & scl_d & sda_d & ~sda_in;
	assign stop_cond  = scl_in & scl_d & ~sda_d & sda_in;
	assign sda_oe     = drive_low;
	assign sda_out    = 1'b0;
	assign store_now  = (state == S_DATA) && scl_fall && (bit_cnt == 4'h8);

	function [7:0] read_reg;
		input [7:0] addr;
		begin
			case (addr)
				`REG_MAIN_CONTROL:  read_reg = main_control;
				`REG_AMPLITUDE:     read_reg = amplitude_setting;
				`REG_PEAKING_LEVEL: read_reg = preemphasis_level;
				`REG_EQUALIZER:     read_reg = equalizer_setting;
				`REG_CONV_SETTINGS: read_reg = converter_settings;
				`REG_CONV_RES_HIGH: read_reg = conv_result[9:2];
				`REG_CONV_RES_LOW:  read_reg = {6'h00, conv_result[1:0]};
				default:            read_reg = 8'h00;
			endcase
		end
	endfunction

	// Writable bits of each register; the unused bits stay zero.
	function [7:0] field_mask;
		input [7:0] addr;
		begin
			case (addr)
				`REG_PEAKING_LEVEL: field_mask = `PEAKING_LEVEL_MASK;
				`REG_CONV_SETTINGS: field_mask = `CONV_SETTINGS_MASK;
				default:            field_mask = 8'hff;
			endcase
		end
	endfunction

	// A control bit that only acts while the chip is enabled.
	function gated_bit;
		input [7:0]   ctrl;
		input integer pos;
		begin
			gated_bit = ctrl[`BIT_CHIP_ON] & ctrl[pos];
		end
	endfunction

	assign read_byte  = read_reg(reg_ptr);

	always @(posedge clk) begin
		if (reset) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_in;
			sda_d <= sda_in;
		end
	end

	// Protocol engine; a write lands at the clock fall ending its data byte, before the acknowledge.
	always @(posedge clk) begin
		if (reset) begin
			state              <= S_IDLE;
			ret_state          <= S_IDLE;
			bit_cnt            <= 4'h0;
			shifter            <= 8'h00;
			reg_ptr            <= 8'h00;
			drive_low          <= 1'b0;
			reading            <= 1'b0;
		end else if (stop_cond) begin
			state     <= S_IDLE;
			drive_low <= 1'b0;
		end else if (start_cond) begin
			state     <= S_ADDR;
			bit_cnt   <= 4'h0;
			drive_low <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					drive_low <= 1'b0;
				end
				S_ADDR, S_REG, S_DATA: begin
					if (scl_rise) begin
						shifter <= {shifter[6:0], sda_in};
						bit_cnt <= bit_cnt + 4'h1;
					end
					if (scl_fall && bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						state   <= S_ACK;
						if (state == S_ADDR) begin
							if (shifter[7:1] == `SLAVE_ADDR) begin
								drive_low <= 1'b1;
								reading   <= shifter[0];
								ret_state <= shifter[0] ? S_READ : S_REG;
							end else begin
								state     <= S_IDLE;
							end
						end else if (state == S_REG) begin
							drive_low <= 1'b1;
							reg_ptr   <= shifter;
							ret_state <= S_DATA;
						end else begin
							drive_low <= 1'b1;
							ret_state <= S_DATA;
							reg_ptr <= reg_ptr + 8'h01;
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						drive_low <= 1'b0;
						state     <= ret_state;
						if (reading) begin
							shifter   <= read_byte;
							drive_low <= ~read_byte[7];
							bit_cnt   <= 4'h1;
						end
					end
				end
				S_READ: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							drive_low <= 1'b0;
							bit_cnt   <= 4'h9;
						end else if (bit_cnt == 4'h9) begin
							drive_low <= 1'b0;
						end else begin
							drive_low <= ~shifter[3'd7 - bit_cnt[2:0]];
							bit_cnt   <= bit_cnt + 4'h1;
						end
					end
					if (scl_rise && bit_cnt == 4'h9) begin
						if (sda_in) begin
							state <= S_IDLE;
						end else begin
							reg_ptr <= reg_ptr + 8'h01;
							state   <= S_ACK;
							ret_state <= S_READ;
						end
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// Register bank; a byte lands at the clock fall that ends its eighth bit.
	always @(posedge clk) begin
		if (reset) begin
			main_control       <= `RESET_MAIN_CONTROL;
			amplitude_setting  <= `RESET_AMPLITUDE;
			preemphasis_level  <= `RESET_PEAKING;
			equalizer_setting  <= `RESET_EQUALIZER;
			converter_settings <= `RESET_CONV_SET;
		end else if (store_now) begin
			case (reg_ptr)
				`REG_MAIN_CONTROL:  main_control       <= shifter;
				`REG_AMPLITUDE:     amplitude_setting  <= shifter;
				`REG_PEAKING_LEVEL: preemphasis_level  <= shifter & field_mask(reg_ptr);
				`REG_EQUALIZER:     equalizer_setting  <= shifter;
				`REG_CONV_SETTINGS: converter_settings <= shifter & field_mask(reg_ptr);
				default: ;
			endcase
		end
	end

	// Decoded controls follow the stored registers.
	always @(posedge clk) begin
		if (reset) begin
			chip_on              <= 1'b0;
			high_termination_sel <= 1'b0;
			peaking_on           <= 1'b0;
			peaking_range        <= 1'b0;
			crossing_adjust_on   <= 1'b0;
			offset_cancel_on     <= 1'b0;
			output_swap          <= 1'b0;
			input_eq_on          <= 1'b0;
			swing_source_sel     <= 1'b0;
			swing_code           <= 8'h00;
			peaking_level        <= 4'h0;
			boost_code           <= 8'hff;
			converter_off        <= 1'b0;
			oscillator_off       <= 1'b0;
			converter_input_sel  <= 1'b0;
		end else begin
			chip_on              <= next_chip_on;
			high_termination_sel <= next_high_termination_sel;
			peaking_on           <= next_peaking_on;
			peaking_range        <= next_peaking_range;
			crossing_adjust_on   <= next_crossing_adjust_on;
			offset_cancel_on     <= next_offset_cancel_on;
			output_swap          <= next_output_swap;
			input_eq_on          <= next_input_eq_on;
			swing_source_sel     <= next_swing_source_sel;
			swing_code           <= next_swing_code;
			peaking_level        <= next_peaking_level;
			boost_code           <= next_boost_code;
			converter_off        <= next_converter_off;
			oscillator_off       <= next_oscillator_off;
			converter_input_sel  <= next_converter_input_sel;
		end
	end

	// Next values of the decoded controls.
	always @* begin
		next_chip_on              = main_control[`BIT_CHIP_ON];
		next_high_termination_sel = main_control[`BIT_HIGH_TERM];
		next_peaking_on           = gated_bit(main_control, `BIT_PEAKING_ON) &
		                            (preemphasis_level[3:0] != 4'h0);
		next_peaking_range        = main_control[`BIT_PEAKING_RANGE];
		next_crossing_adjust_on   = gated_bit(main_control, `BIT_CROSSING_ADJ);
		next_offset_cancel_on     = main_control[`BIT_CHIP_ON] &
		                            ~main_control[`BIT_CROSSING_ADJ];
		next_output_swap          = main_control[`BIT_OUTPUT_SWAP];
		next_input_eq_on          = gated_bit(main_control, `BIT_INPUT_EQ_ON);
		next_swing_source_sel     = main_control[`BIT_SWING_SOURCE];
		next_swing_code           = amplitude_setting;
		next_peaking_level        = main_control[`BIT_PEAKING_ON] ?
		                            preemphasis_level[3:0] : 4'h0;
		next_boost_code           = main_control[`BIT_INPUT_EQ_ON] ?
		                            equalizer_setting : 8'hff;
		next_converter_off        = converter_settings[`BIT_CONVERTER_OFF];
		next_oscillator_off       = converter_settings[`BIT_OSCILLATOR_OFF];
		next_converter_input_sel  = converter_settings[`BIT_CONV_INPUT_SEL];
	end

endmodule

// ---- bench/driver_ctrl_checker.sv ----
// Concurrent checks on the control bank ports.
`timescale 1ns/100ps
module driver_ctrl_checker (
	// Clock, reset and serial pins
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       scl_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	// Controls
	input wire logic       chip_on,
	input wire logic       peaking_on,
	input wire logic       crossing_adjust_on,
	input wire logic       offset_cancel_on,
	input wire logic       input_eq_on,
	input wire logic [3:0] peaking_level,
	input wire logic [7:0] boost_code,
	input wire logic [7:0] swing_code
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_cross_exclusive: assert property (chip_on |-> crossing_adjust_on != offset_cancel_on)
		else $error("cross-point and offset cancel not exclusive");
	a_chip_off_quiet: assert property (!chip_on |-> !(peaking_on || input_eq_on ||
		crossing_adjust_on || offset_cancel_on)) else $error("function on while chip off");
	a_level_zero_off: assert property (peaking_level == 4'h0 |-> !peaking_on)
		else $error("pre-emphasis on with zero level");
	a_eq_bypass_code: assert property (chip_on && !input_eq_on |-> boost_code == 8'hff)
		else $error("boost code not neutral while bypassed");
	a_eq_needs_chip: assert property (input_eq_on |-> chip_on)
		else $error("equalizer on while chip off");
	a_sda_open_drain: assert property (sda_out == 1'b0)
		else $error("data pin driven high");
	a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data pin changed while clock high");
	a_ack_held: assert property ($rose(sda_oe) |=> sda_oe [*3])
		else $error("acknowledge dropped early");
	a_ctrl_settle: assert property ($changed({swing_code, peaking_level, boost_code})
		|-> !scl_in) else $error("setting changed inside a bit");
endmodule
bind driver_ctrl_regs driver_ctrl_checker u_chk (.clk(clk), .reset(reset),
	.scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .chip_on(chip_on),
	.peaking_on(peaking_on), .crossing_adjust_on(crossing_adjust_on),
	.offset_cancel_on(offset_cancel_on), .input_eq_on(input_eq_on),
	.peaking_level(peaking_level), .boost_code(boost_code), .swing_code(swing_code));

// ---- bench/serial_host_model.sv ----
// Two-wire host controller model driving the control bank pins.
`timescale 1ns/100ps
`include "driver_ctrl_map.vh"
module serial_host_model (
	// Clock and line
	input  wire logic clk,
	input  wire logic sda_line,
	// Host pins
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic qw();
		repeat (5) @(posedge clk);
	endtask
	task automatic start();
		sda_low <= 1'b0;
		qw();
		scl <= 1'b1;
		qw();
		sda_low <= 1'b1;
		qw();
		scl <= 1'b0;
		qw();
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		qw();
		scl <= 1'b1;
		qw();
		sda_low <= 1'b0;
		qw();
	endtask
	task automatic put_bit(input logic b);
		sda_low <= !b;
		qw();
		scl <= 1'b1;
		qw();
		scl <= 1'b0;
		qw();
	endtask
	task automatic get_bit(output logic b);
		sda_low <= 1'b0;
		qw();
		scl <= 1'b1;
		qw();
		b = sda_line;
		scl <= 1'b0;
		qw();
	endtask
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(b);
		ack = !b;
	endtask
	task automatic write_reg(input logic [7:0] a, d, output logic ok);
		logic a0, a1, a2;
		start();
		send_byte({`SLAVE_ADDR, 1'b0}, a0);
		send_byte(a, a1);
		send_byte(d, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		send_byte({`SLAVE_ADDR, 1'b0}, a0);
		send_byte(a, a1);
		start();
		send_byte({`SLAVE_ADDR, 1'b1}, a2);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(1'b1);
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule

// ---- bench/modulator_driver_control_regs_test.sv ----
// Self-checking bench for the modulator driver control bank.
`timescale 1ns/100ps
`include "driver_ctrl_map.vh"
module modulator_driver_control_regs_test;
	// Clock, reset and pins
	logic       clk, reset, scl, host_low, sda_oe, sda_out, ok, ack;
	logic [9:0] conv_result;
	wire        sda = !(host_low || sda_oe);
	// Controls
	logic       chip_on, high_termination_sel, peaking_on, peaking_range, crossing_adjust_on;
	logic       offset_cancel_on, output_swap, input_eq_on, swing_source_sel;
	logic       converter_off, oscillator_off, converter_input_sel;
	logic [7:0] swing_code, boost_code;
	logic [3:0] peaking_level;
	int         err_count = 0, tests_run = 0;
	driver_ctrl_regs u_dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .conv_result(conv_result), .chip_on(chip_on),
		.high_termination_sel(high_termination_sel), .peaking_on(peaking_on),
		.peaking_range(peaking_range), .crossing_adjust_on(crossing_adjust_on),
		.offset_cancel_on(offset_cancel_on), .output_swap(output_swap),
		.input_eq_on(input_eq_on), .swing_source_sel(swing_source_sel),
		.swing_code(swing_code), .peaking_level(peaking_level), .boost_code(boost_code),
		.converter_off(converter_off), .oscillator_off(oscillator_off),
		.converter_input_sel(converter_input_sel));
	serial_host_model host (.clk(clk), .sda_line(sda), .scl(scl), .sda_low(host_low));
	task automatic compare(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		host.write_reg(a, d, ok);
		compare(ok, 1);
		repeat (3) @(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, exp);
		logic [7:0] d;
		host.read_reg(a, d, ok);
		compare({ok, d}, {1'b1, exp});
	endtask
	task automatic test_reset_values();
		compare({chip_on, high_termination_sel, peaking_on, peaking_range, crossing_adjust_on,
			offset_cancel_on, output_swap, input_eq_on, swing_source_sel, converter_off,
			oscillator_off, converter_input_sel, peaking_level, swing_code, boost_code},
			{12'h000, 4'h0, 8'h00, 8'hff});
		rd(`REG_MAIN_CONTROL, 8'h00);
		rd(`REG_AMPLITUDE, 8'h00);
		rd(`REG_PEAKING_LEVEL, 8'h00);
		rd(`REG_EQUALIZER, 8'hff);
		rd(`REG_CONV_SETTINGS, 8'h00);
		$display("reset values done");
	endtask
	task automatic test_controls();
		logic [7:0] tbl [6] = '{8'hff, 8'h7f, 8'h80, 8'haa, 8'h55, 8'hdf};
		logic [7:0] c;
		wr(`REG_PEAKING_LEVEL, 8'hf5);
		rd(`REG_PEAKING_LEVEL, 8'h05);
		wr(`REG_EQUALIZER, 8'h3c);
		wr(`REG_AMPLITUDE, 8'ha7);
		rd(`REG_AMPLITUDE, 8'ha7);
		foreach (tbl[i]) begin
			c = tbl[i];
			wr(`REG_MAIN_CONTROL, c);
			compare({chip_on, high_termination_sel, peaking_on, peaking_range,
				crossing_adjust_on, offset_cancel_on, output_swap, input_eq_on, swing_source_sel,
				peaking_level, boost_code, swing_code}, {c[7], c[6], c[7] & c[5], c[4],
				c[7] & c[3], c[7] & ~c[3], c[2], c[7] & c[1], c[0],
				c[5] ? 4'h5 : 4'h0, c[1] ? 8'h3c : 8'hff, 8'ha7});
		end
		wr(`REG_MAIN_CONTROL, 8'hff);
		wr(`REG_PEAKING_LEVEL, 8'h00);
		compare({peaking_on, peaking_level}, 5'h00);
		$display("control bits done");
	endtask
	task automatic test_converter();
		conv_result <= 10'h2b6;
		wr(`REG_CONV_SETTINGS, 8'hff);
		rd(`REG_CONV_SETTINGS, 8'hc1);
		compare({converter_off, oscillator_off, converter_input_sel}, 3'b111);
		wr(`REG_CONV_SETTINGS, 8'h80);
		compare({converter_off, oscillator_off, converter_input_sel}, 3'b100);
		wr(`REG_CONV_SETTINGS, 8'h41);
		compare({converter_off, oscillator_off, converter_input_sel}, 3'b011);
		rd(`REG_CONV_RES_HIGH, 8'had);
		rd(`REG_CONV_RES_LOW, 8'h02);
		conv_result <= 10'h15d;
		rd(`REG_CONV_RES_HIGH, 8'h57);
		rd(`REG_CONV_RES_LOW, 8'h01);
		host.write_reg(`REG_CONV_RES_HIGH, 8'h55, ok);
		rd(`REG_CONV_RES_HIGH, 8'h57);
		rd(8'h08, 8'h00);
		$display("converter done");
	endtask
	task automatic test_refused();
		host.start();
		host.send_byte({7'h09, 1'b0}, ack);
		host.stop();
		compare(ack, 0);
		host.start();
		host.send_byte({`SLAVE_ADDR, 1'b0}, ack);
		host.send_byte(`REG_AMPLITUDE, ack);
		host.stop();
		compare(swing_code, 8'ha7);
		wr(`REG_AMPLITUDE, 8'h5a);
		compare({swing_code, boost_code}, 16'h5a3c);
		$display("refusals done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
	initial begin
		reset = 1'b1;
		conv_result = 10'h000;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		test_reset_values();
		test_controls();
		test_converter();
		test_refused();
		tally_and_finish();
	end
endmodule
